/* bench/testbench.sv */
// Self-checking bench for the highway control block, driven over APB.
// Assumes the package, the design and the far-side model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "thc_consts.svh"
module testbench;
  localparam logic [11:0] CTL = `THC_CTRL_OFFSET;
  localparam logic [11:0] DMA = `THC_DMA_OFFSET;
  localparam logic [11:0] TXW = `THC_TXDATA_OFFSET;
  localparam logic [11:0] RXW = `THC_RXDATA_OFFSET;
  localparam logic [11:0] STS = `THC_STATUS_OFFSET;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cfg, r;
  logic        master, sync_oe, sync_out, data_out, data_oe, rx_act;
  logic        tx_act, far_clk, far_sync, far_data, sync_lvl, e, dbl, d, er;
  logic [7:0]  w, heard;
  int          err_count, n_tests, c0;
  int          oe_cnt = 0;
  wire logic   sync_pin = sync_oe ? sync_out : far_sync;
  // A released data line rests at its pull-up level.
  wire logic   data_pin = data_oe ? data_out : 1'b1;

  // Free-running 200 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  thc_highway DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .highway_bit_clock(far_clk), .highway_frame_sync_in(sync_pin),
    .highway_frame_sync_out(sync_out), .highway_frame_sync_oe(sync_oe),
    .highway_master(master), .serial_data_in(far_data),
    .serial_data_out(data_out), .serial_data_oe(data_oe),
    .receive_active(rx_act), .transmit_active(tx_act));
  thc_far_end far (.bit_clock(far_clk), .frame_sync(far_sync),
    .data(far_data), .rx_line(data_pin), .heard(heard));

  // Counts cycles with the data pin driven; sync rises record the
  // level the bit clock took at its last edge.
  always @(posedge pclk) oe_cnt <= oe_cnt + int'(data_oe === 1'b1);
  always @(posedge sync_out) sync_lvl = far_clk;

  // Compares and counts; a mismatch is reported at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  // One APB transfer, entered just after a rising edge; an idle cycle
  // follows, so no signal is assigned twice in one time step.
  task automatic apb(input logic wr_n, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rv,
                     output logic ev);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_n;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    ev = pslverr;
    if (n >= 20)
      err_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic        y;
    apb(1'b1, a, wd, x, y);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic        y;
    apb(1'b0, a, 32'h0, x, y);
    chk(x, exp);
  endtask

  // A frame from the far side, then realignment to the clock edge.
  task automatic send(input logic se, input logic sd, input logic sy,
                      input logic [7:0] sw);
    far.frame(se, sd, sy, sw);
    repeat (4) @(posedge pclk);
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Cuts a hang short; the tests need about ten microseconds.
  initial begin
    #200us;
    err_count++;
    stop_test();
  end

  initial begin
    {psel, penable, pwrite, master} = 4'h0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    presetn   = 1'b0;
    err_count = 0;
    n_tests   = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CTL, 32'h0);
    rd(DMA, 32'h0);
    wr(CTL, 32'h3e);
    rd(CTL, 32'h3e);
    chk({31'h0, rx_act}, 32'h0);
    apb(1'b0, 12'h020, 32'h0, r, er);
    chk({31'h0, er}, 32'h1);
    chk(r, 32'h0);
    wr(CTL, 32'h0);
    // Every sample edge with both clock ratios; word is c4..c7.
    for (int k = 0; k < 4; k++) begin
      {dbl, e} = k[1:0];
      w = {6'h31, k[1:0]};
      cfg = {26'h0, e, 1'b0, dbl, 3'b000};
      far.idle(~e);
      wr(CTL, cfg);
      wr(CTL, cfg | 32'h4);
      wr(CTL, cfg | 32'h5);
      @(posedge pclk);
      chk({31'h0, rx_act}, 32'h1);
      send(e, dbl, 1'b1, w);
      rd(RXW, {24'h0, w});
      wr(CTL, cfg | 32'h4);
      @(posedge pclk);
      chk({31'h0, rx_act}, 32'h0);
      rd(CTL, cfg | 32'h4);
    end
    // Three words into the two-entry buffer: the third overruns.
    wr(CTL, 32'h24);
    wr(CTL, 32'h25);
    for (int i = 1; i < 4; i++)
      send(1'b1, 1'b0, 1'b1, {i[3:0], i[3:0]});
    rd(STS, 32'h0a);
    rd(RXW, 32'h11);
    rd(RXW, 32'h22);
    wr(STS, 32'h08);
    rd(STS, 32'h00);
    // Receive off drops the word; under DMA the direct enables are ignored.
    wr(CTL, 32'h24);
    wr(CTL, 32'h22);
    wr(CTL, 32'h23);
    send(1'b1, 1'b0, 1'b1, 8'h5c);
    rd(STS, 32'h0);
    wr(CTL, 32'h22);
    wr(DMA, 32'h3);
    rd(DMA, 32'h3);
    wr(CTL, 32'h20);
    wr(CTL, 32'h21);
    send(1'b1, 1'b0, 1'b1, 8'h5c);
    chk({30'h0, tx_act, rx_act}, 32'h3);
    rd(STS, 32'h1);
    rd(RXW, 32'h5c);
    wr(CTL, 32'h20);
    wr(DMA, 32'h0);
    // Sync master, both drive edges; transmit off then on.
    master <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      d = k[0];
      cfg = {26'h0, ~d, d, 4'h0};
      far.idle(d);
      wr(CTL, cfg | 32'h4);
      wr(CTL, cfg | 32'h5);
      c0 = oe_cnt;
      send(~d, 1'b0, 1'b0, 8'h00);
      chk(32'(oe_cnt - c0), 32'h0);
      wr(CTL, cfg | 32'h4);
      wr(TXW, 32'h5a);
      wr(CTL, cfg | 32'h2);
      wr(CTL, cfg | 32'h3);
      @(posedge pclk);
      chk({30'h0, sync_oe, tx_act}, 32'h3);
      c0 = oe_cnt;
      sync_lvl = 1'bx;
      send(~d, 1'b0, 1'b0, 8'h00);
      chk({31'h0, sync_lvl}, {31'h0, d});
      chk({31'h0, oe_cnt != c0}, 32'h1);
      chk({24'h0, heard}, 32'h5a);
      wr(CTL, cfg | 32'h2);
    end
    wr(CTL, 32'h0);
    stop_test();
  end
endmodule // testbench
`default_nettype wire

/* bench/thc_far_end.sv */
// Far-side model of the serial highway: bit clock, frame sync and data.
// Assumes the bench calls frame() and idle() from its main sequence.
`timescale 1ns/1ps
`default_nettype none
module thc_far_end (
  output var  logic       bit_clock,
  output var  logic       frame_sync,
  output var  logic       data,
  input  wire logic       rx_line,
  output var  logic [7:0] heard
);
  // Lines start low; the clock only runs inside a frame.
  initial begin
    bit_clock  = 1'b0;
    frame_sync = 1'b0;
    data       = 1'b0;
    heard      = 8'h00;
  end

  // Parks the clock at a level; done with the block off, so that the
  // level change cannot count as an edge.
  task automatic idle(input logic lvl);
    #0.5 bit_clock = lvl;
  endtask

  // One frame: a sync slot, then the word MSB first. Lines change on the
  // edge opposite the sample edge, so they are stable where sampled. A
  // double-rate bit is held over two clocks, since either sample may
  // carry it. Changes fall on whole nanoseconds, clear of rising pclk edges.
  task automatic frame(input logic e, input logic dbl, input logic syn,
                       input logic [7:0] w);
    int n;
    n = dbl ? 17 : 9;
    #0.5 bit_clock = ~e;
    #100;
    for (int s = 0; s < n + 2; s++) begin
      frame_sync = syn && (s == 0);
      if (s == 0 || s >= n)
        data = ~data; // Outside the word the line keeps moving.
      else
        data = w[7 - (dbl ? (s - 1) / 2 : s - 1)];
      #24 bit_clock = e;
      // With the device as sync master, its word follows one slot later;
      // only frames sent without sync are listened to, in slots 2 to 9.
      if (!syn && s >= 2 && s < 10)
        heard = {heard[6:0], rx_line};
      #24 bit_clock = ~e;
    end
    frame_sync = 1'b0;
    data       = ~data;
  endtask
endmodule // thc_far_end
`default_nettype wire

/* hdl/thc_consts.svh */
// Constants for the highway control block: offsets, bit positions, reset value, word width.
// Assumes inclusion by the package, the design file and the testbench, once each.
`ifndef THC_CONSTS_SVH
`define THC_CONSTS_SVH
`define THC_CTRL_OFFSET     12'h000
`define THC_DMA_OFFSET      12'h004
`define THC_TXDATA_OFFSET   12'h008
`define THC_RXDATA_OFFSET   12'h00c
`define THC_STATUS_OFFSET   12'h010
`define THC_BIT_SAMPLE_EDGE 5
`define THC_BIT_DRIVE_EDGE  4
`define THC_BIT_DOUBLE      3
`define THC_BIT_RX_EN       2
`define THC_BIT_TX_EN       1
`define THC_BIT_MOD_EN      0
`define THC_CTRL_RESET      6'h00
`define THC_BIT_RXDMA       0
`define THC_BIT_TXDMA       1
`define THC_WORD_BITS       8
`endif

/* hdl/thc_highway.sv */
// Control portion of a TDM serial highway with an APB register slave.
// Assumes bit clock, frame sync and data pins are asynchronous to pclk.
//
// Operation
// RQ1: Sample-edge bit 5 picks the clock edge that samples sync; 0 falling.
// RQ2: As sync master, software sets sample edge to inverse of drive edge.
// RQ3: Drive-edge bit 4 picks the clock edge launching sync; 0 falling.
// RQ4: Bit 3 zero means one clock per bit; one means two clocks.
// RQ5: Bit 2 enables direct receive; when clear received data is dropped.
// RQ6: Direct receive enable is ignored while receive DMA is on.
// RQ7: Bit 1 enables direct transmit through the transmit holding word; the code loads that word for sending only while highway_master is set.
// RQ8: With direct transmit enable clear the data pin is not driven.
// RQ9: Direct transmit enable is ignored while transmit DMA is on.
// RQ10: Bit 0 clear holds serial logic in reset; register keeps contents.
// RQ11: Software programs configuration fields before any enable.
// RQ12: Software then sets a receive and/or transmit direction enable.
// RQ13: Software sets the module enable last when starting.
// RQ14: To stop, software clears the module enable first.
// RQ15: Software then clears the DMA enables that were set.
// RQ16: All control fields reset to zero and are read/write.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "thc_consts.svh"
module thc_highway
  import thc_pkg::*;
#(
  parameter int WORD_BITS = `THC_WORD_BITS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        highway_bit_clock,
  input  wire logic        highway_frame_sync_in,
  output var  logic        highway_frame_sync_out,
  output var  logic        highway_frame_sync_oe,
  input  wire logic        highway_master,
  input  wire logic        serial_data_in,
  output var  logic        serial_data_out,
  output var  logic        serial_data_oe,
  output var  logic        receive_active,
  output var  logic        transmit_active
);

  // Register state.
  thc_ctrl_t ctrl_reg, ctrl_next;
  thc_dma_t  dma_reg, dma_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic [WORD_BITS-1:0] tx_hold_reg, tx_hold_next;
  logic        tx_hold_full_reg, tx_hold_full_next;
  // Two-entry receive buffer, drained by reads of the receive word.
  logic [WORD_BITS-1:0] rx_buf_reg [2];
  logic [WORD_BITS-1:0] rx_buf_next [2];
  logic [1:0]  rx_cnt_reg, rx_cnt_next;
  logic        rx_overrun_reg, rx_overrun_next;

  // Synchronisers and serial state.
  logic [1:0] clk_sync_reg, fs_sync_reg, din_sync_reg;
  logic       clk_prev_reg;
  logic       half_reg, half_next;
  logic [WORD_BITS-1:0] rx_shift_reg, rx_shift_next;
  logic [WORD_BITS-1:0] tx_shift_reg, tx_shift_next;
  logic [$clog2(WORD_BITS):0] bit_cnt_reg, bit_cnt_next;
  logic       in_frame_reg, in_frame_next;
  logic       fs_out_reg, fs_out_next;
  logic       dout_reg, dout_next;
  logic       doe_reg, doe_next;
  logic       fs_oe_reg, fs_oe_next;
  logic       rx_act_reg, rx_act_next;
  logic       tx_act_reg, tx_act_next;
  logic [WORD_BITS-1:0] rx_word;
  logic       rx_push;
  logic       tx_pop;

  logic rd_en;
  logic rise, fall, sample_ev, drive_ev, rx_on, tx_on, ser_rst;

  assign rd_en = psel && penable && !pready_reg && !pwrite;

  // Edge detection reads only the second synchroniser stage.
  assign rise = clk_sync_reg[1] && !clk_prev_reg;
  assign fall = !clk_sync_reg[1] && clk_prev_reg;
  assign sample_ev = ctrl_reg.sample_edge ? rise : fall; // RQ1
  assign drive_ev  = ctrl_reg.drive_edge ? rise : fall;  // RQ3
  // Direct enables have no say while the matching DMA path is on.
  assign rx_on = dma_reg.rx_dma || ctrl_reg.rx_en; // RQ5 RQ6
  assign tx_on = dma_reg.tx_dma || ctrl_reg.tx_en; // RQ7 RQ9
  assign ser_rst = !ctrl_reg.mod_en; // RQ10

  // APB slave: one wait state, so the answer lands two cycles after setup.
  always_comb begin
    ctrl_next = ctrl_reg;
    dma_next = dma_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    tx_hold_next = tx_hold_reg;
    tx_hold_full_next = tx_hold_full_reg && !tx_pop;
    rx_buf_next = rx_buf_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_overrun_next = rx_overrun_reg;
    if (rd_en && paddr == `THC_RXDATA_OFFSET && rx_cnt_reg != 2'd0) begin
      rx_buf_next[0] = rx_buf_reg[1];
      rx_cnt_next = rx_cnt_reg - 2'd1;
    end
    if (rx_push) begin
      if (rx_cnt_next == 2'd2) begin
        rx_overrun_next = 1'b1;
      end else begin
        rx_buf_next[rx_cnt_next[0]] = rx_word;
        rx_cnt_next = rx_cnt_next + 2'd1;
      end
    end
    if (ser_rst) begin
      rx_cnt_next = 2'd0;
    end
    if (psel && penable && !pready_reg) begin
      pready_next = 1'b1;
      prdata_next = 32'h0000_0000;
      case (paddr)
        `THC_CTRL_OFFSET: begin
          if (pwrite) begin
            ctrl_next = thc_ctrl_t'(pwdata[5:0]); // RQ16
          end
          prdata_next[5:0] = ctrl_reg;
        end
        `THC_DMA_OFFSET: begin
          if (pwrite) begin
            dma_next.rx_dma = pwdata[`THC_BIT_RXDMA];
            dma_next.tx_dma = pwdata[`THC_BIT_TXDMA];
          end
          prdata_next[`THC_BIT_RXDMA] = dma_reg.rx_dma;
          prdata_next[`THC_BIT_TXDMA] = dma_reg.tx_dma;
        end
        `THC_TXDATA_OFFSET: begin
          if (pwrite) begin
            tx_hold_next = pwdata[WORD_BITS-1:0];
            tx_hold_full_next = 1'b1;
          end
          prdata_next[WORD_BITS-1:0] = tx_hold_reg;
        end
        `THC_RXDATA_OFFSET: begin
          prdata_next[WORD_BITS-1:0] = rx_buf_reg[0];
        end
        `THC_STATUS_OFFSET: begin
          if (pwrite && pwdata[3]) begin
            rx_overrun_next = 1'b0;
          end
          prdata_next[3:0] = {rx_overrun_reg, tx_hold_full_reg, rx_cnt_reg};
        end
        default: begin
          pslverr_next = 1'b1;
        end
      endcase
      if (rx_push && rx_cnt_reg == 2'd2) begin
        rx_overrun_next = 1'b1; // A new overrun wins over the clear.
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= thc_ctrl_t'(`THC_CTRL_RESET); // RQ16
      dma_reg <= '0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      tx_hold_reg <= '0;
      tx_hold_full_reg <= 1'b0;
      rx_buf_reg[0] <= '0;
      rx_buf_reg[1] <= '0;
      rx_cnt_reg <= 2'd0;
      rx_overrun_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      dma_reg <= dma_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      tx_hold_reg <= tx_hold_next;
      tx_hold_full_reg <= tx_hold_full_next;
      rx_buf_reg <= rx_buf_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_overrun_reg <= rx_overrun_next;
    end
  end

  // Serial engine: frame starts at the sampled sync, bits counted per edge.
  // In double-rate mode only every second sample edge carries a bit.
  always_comb begin
    half_next = half_reg;
    rx_shift_next = rx_shift_reg;
    tx_shift_next = tx_shift_reg;
    bit_cnt_next = bit_cnt_reg;
    in_frame_next = in_frame_reg;
    fs_out_next = fs_out_reg;
    dout_next = dout_reg;
    rx_push = 1'b0;
    tx_pop = 1'b0;
    rx_word = rx_shift_reg;
    if (sample_ev) begin
      half_next = ctrl_reg.double_rate ? !half_reg : 1'b0; // RQ4
      if (fs_sync_reg[1]) begin
        in_frame_next = 1'b1;
        bit_cnt_next = '0;
        half_next = ctrl_reg.double_rate; // RQ4
      end else if (in_frame_reg && !half_reg) begin
        rx_shift_next = {rx_shift_reg[WORD_BITS-2:0], din_sync_reg[1]};
        rx_word = rx_shift_next;
        bit_cnt_next = bit_cnt_reg + 1'b1;
        if (bit_cnt_reg == ($clog2(WORD_BITS)+1)'(WORD_BITS-1)) begin
          in_frame_next = 1'b0;
          rx_push = rx_on; // RQ5
        end
      end
    end
    if (drive_ev) begin
      // Master sync pulses once per word, launched on the drive edge. The
      // held word loads at that same edge, so that its first bit is out
      // before the first data sample edge of the frame.
      fs_out_next = highway_master && !in_frame_reg && !fs_out_reg; // RQ3
      if (fs_out_next && tx_hold_full_reg) begin
        tx_shift_next = tx_hold_reg;
        tx_pop = tx_on;
      end else if (in_frame_reg && !half_reg) begin
        dout_next = tx_shift_reg[WORD_BITS-1];
        tx_shift_next = {tx_shift_reg[WORD_BITS-2:0], 1'b0};
      end
    end
    if (ser_rst) begin // RQ10
      half_next = 1'b0;
      bit_cnt_next = '0;
      in_frame_next = 1'b0;
      fs_out_next = 1'b0;
      dout_next = 1'b0;
      rx_push = 1'b0;
      tx_pop = 1'b0;
    end
    doe_next = !ser_rst && tx_on; // RQ8 RQ9
    fs_oe_next = !ser_rst && highway_master;
    rx_act_next = !ser_rst && rx_on;
    tx_act_next = !ser_rst && tx_on;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sync_reg <= 2'b00;
      fs_sync_reg <= 2'b00;
      din_sync_reg <= 2'b00;
      clk_prev_reg <= 1'b0;
      half_reg <= 1'b0;
      rx_shift_reg <= '0;
      tx_shift_reg <= '0;
      bit_cnt_reg <= '0;
      in_frame_reg <= 1'b0;
      fs_out_reg <= 1'b0;
      dout_reg <= 1'b0;
      doe_reg <= 1'b0;
      fs_oe_reg <= 1'b0;
      rx_act_reg <= 1'b0;
      tx_act_reg <= 1'b0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], highway_bit_clock};
      fs_sync_reg <= {fs_sync_reg[0], highway_frame_sync_in};
      din_sync_reg <= {din_sync_reg[0], serial_data_in};
      clk_prev_reg <= clk_sync_reg[1];
      half_reg <= half_next;
      rx_shift_reg <= rx_shift_next;
      tx_shift_reg <= tx_shift_next;
      bit_cnt_reg <= bit_cnt_next;
      in_frame_reg <= in_frame_next;
      fs_out_reg <= fs_out_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      fs_oe_reg <= fs_oe_next;
      rx_act_reg <= rx_act_next;
      tx_act_reg <= tx_act_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign highway_frame_sync_out = fs_out_reg;
  assign highway_frame_sync_oe = fs_oe_reg;
  assign serial_data_out = dout_reg;
  assign serial_data_oe = doe_reg;
  assign receive_active = rx_act_reg;
  assign transmit_active = tx_act_reg;

  // Checks on the control path.
  a_ctrl_reset: assert property ( // RQ16
    @(posedge pclk) $rose(presetn) |-> ctrl_reg == '0)
    else $error("control not zero after reset");
  a_tx_tristate: assert property ( // RQ8
    @(posedge pclk) disable iff (!presetn)
    (!ctrl_reg.tx_en && !dma_reg.tx_dma) |=> !serial_data_oe)
    else $error("data driven while transmit off");
  a_tx_dma_wins: assert property ( // RQ9
    @(posedge pclk) disable iff (!presetn)
    (dma_reg.tx_dma && ctrl_reg.mod_en) |=> serial_data_oe)
    else $error("transmit dma not overriding");
  a_rx_dma_wins: assert property ( // RQ6
    @(posedge pclk) disable iff (!presetn)
    (dma_reg.rx_dma && ctrl_reg.mod_en) |=> receive_active)
    else $error("receive dma not overriding");
  a_rx_drop: assert property ( // RQ5
    @(posedge pclk) disable iff (!presetn)
    rx_push |-> (ctrl_reg.rx_en || dma_reg.rx_dma))
    else $error("word kept while receive off");
  a_hold_reset: assert property ( // RQ10
    @(posedge pclk) disable iff (!presetn)
    !ctrl_reg.mod_en |=> (!in_frame_reg && !highway_frame_sync_out))
    else $error("serial logic not held");
  // A frame may only open on a clock change towards the selected level.
  a_sample_edge: assert property ( // RQ1
    @(posedge pclk) disable iff (!presetn) $rose(in_frame_reg)
    |-> ($past(clk_sync_reg[1]) == $past(ctrl_reg.sample_edge))
    && ($past(clk_prev_reg) != $past(clk_sync_reg[1])))
    else $error("sync sampled on wrong edge");
  a_drive_edge: assert property ( // RQ3
    @(posedge pclk) disable iff (!presetn) $rose(highway_frame_sync_out)
    |-> $past(ctrl_reg.drive_edge) == $past(clk_sync_reg[1]))
    else $error("sync launched on wrong edge");
  a_double_skip: assert property ( // RQ4
    @(posedge pclk) disable iff (!presetn)
    (!ctrl_reg.double_rate && sample_ev && !ser_rst) |=> !half_reg)
    else $error("single rate skipped an edge");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready held two cycles");
  c_frame_rx: cover property (@(posedge pclk) rx_push);
  c_tx_load: cover property (@(posedge pclk) tx_pop);
  c_overrun: cover property (@(posedge pclk) $rose(rx_overrun_reg));
  c_bad_addr: cover property (@(posedge pclk) pslverr);
endmodule // thc_highway
`default_nettype wire

/* hdl/thc_pkg.sv */
// Types shared by the highway control block.
// Assumes the constants header sits beside it.
`include "thc_consts.svh"
package thc_pkg;
  typedef struct packed {
    logic sample_edge;
    logic drive_edge;
    logic double_rate;
    logic rx_en;
    logic tx_en;
    logic mod_en;
  } thc_ctrl_t;
  typedef struct packed {
    logic rx_dma;
    logic tx_dma;
  } thc_dma_t;
  typedef enum logic [2:0] {
    THC_IDLE  = 3'b001,
    THC_SETUP = 3'b010,
    THC_ACC   = 3'b100
  } thc_apb_t;
endpackage
